// >>> design/psacc_pkg.sv
// Shared constants and types of the phase skewed accumulator
package psacc_pkg;

    localparam int PSACC_BITS  = 20;             // Data stages
    localparam int PSACC_XW    = 2;              // Partial top stage width
    localparam int PSACC_PH    = 5;              // Clock phases 00..08
    localparam logic PSACC_PAR_ODD = 1'b1;       // Operand word parity sense

    // Operations selected by the control unit pulse lines
    typedef enum logic [2:0] {
        PSACC_ADD_MD,
        PSACC_SUB_MD,
        PSACC_ADD_AUX,
        PSACC_SUB_AUX,
        PSACC_SHL,
        PSACC_CLR,
        PSACC_CMP,
        PSACC_MUL
    } psacc_op_t;

    // Per-stage control lines, common to all stages during a wave
    typedef struct packed {
        logic recirc;      // Keep the stored bit circulating
        logic inv_acc;     // Complement the stored bit
        logic use_md;      // Operand from multiplicand-divisor word
        logic use_aux;     // Operand from auxiliary word
        logic inv_opnd;    // Complement the operand (subtract)
        logic self_add;    // Second adder adds the bit to itself
        logic mul_hi;      // Second adder takes twice the multiplicand
    } psacc_ctl_t;

endpackage : psacc_pkg

// >>> design/psacc_stage.sv
// One accumulator bit stage: adder-subtractor, second adder, loop
`timescale 1ns/100ps
`default_nettype none

module psacc_stage
    import psacc_pkg::*;
(
    input wire logic     clock,
    input wire logic     sys_rst,
    psacc_stage_if.stg   sif
);

    // ==========================================================
    // State
    typedef struct packed {
        logic bit_v;
        logic c1;
        logic c2;
    } psacc_sst_t;

    psacc_sst_t q_r;
    psacc_sst_t q_nxt;
    logic       a;
    logic       o;
    logic       s1;
    logic       b;

    // ==========================================================
    // Datapath
    always_comb begin
        q_nxt = q_r;
        a  = (sif.ctl.recirc & q_r.bit_v) ^ sif.ctl.inv_acc;
        o  = ((sif.ctl.use_md & sif.md_b) | (sif.ctl.use_aux & sif.aux_b))
             ^ sif.ctl.inv_opnd;
        s1 = a ^ o ^ sif.cin1;
        // Self-add doubles through the carry, so the shift ripples too
        b  = (sif.ctl.self_add & a) | (sif.ctl.mul_hi & sif.md_lo);
        if (sif.go) begin
            q_nxt.bit_v = s1 ^ b ^ sif.cin2;
            q_nxt.c1    = (a & o) | (a & sif.cin1) | (o & sif.cin1);
            q_nxt.c2    = (s1 & b) | (s1 & sif.cin2) | (b & sif.cin2);
        end else if (sif.load) begin
            q_nxt.bit_v = sif.load_bit;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign sif.bit_q = q_r.bit_v;
    assign sif.c1_q  = q_r.c1;
    assign sif.c2_q  = q_r.c2;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    stage_hold_a: assert property (!sif.go && !sif.load |=> $stable(q_r.bit_v))
        else $error("stage bit changed without a go or load");
    stage_clear_a: assert property (sif.go && sif.ctl == '0 && !sif.cin1
        && !sif.cin2 |=> !q_r.bit_v)
        else $error("stage not cleared with recirculation off");

endmodule : psacc_stage

`default_nettype wire

// >>> design/psacc_stage_if.sv
// Signals between the accumulator sequencer and one bit stage
`timescale 1ns/100ps
`default_nettype none

interface psacc_stage_if;
    import psacc_pkg::*;
    logic       go;
    logic       load;
    logic       load_bit;
    logic       cin1;
    logic       cin2;
    logic       md_b;
    logic       md_lo;
    logic       aux_b;
    psacc_ctl_t ctl;
    logic       bit_q;
    logic       c1_q;
    logic       c2_q;

    modport seq (output go, load, load_bit, cin1, cin2, md_b, md_lo, aux_b,
                 output ctl, input bit_q, c1_q, c2_q);
    modport stg (input go, load, load_bit, cin1, cin2, md_b, md_lo, aux_b,
                 input ctl, output bit_q, c1_q, c2_q);
endinterface : psacc_stage_if

`default_nettype wire

// >>> design/psacc_top.sv
// Phase skewed accumulator: twenty bit stages and their sequencer
// What this block does
// - Twenty identical bit stages, a partial twenty-first stage, top carry detect.
// - Each stage samples its bit of operand word, auxiliary word, own bit.
// - Each stage owns adder, adder-subtractor, loop and its own output bit.
// - Stage n acts one phase after stage n-1; carries ripple upward.
// - Stages hold adder, adder-subtractor, shift, loop; control selects the operation.
// - Adder-subtractor adds or subtracts operand word or auxiliary word.
// - A subtraction that borrows is complemented and its sign reversed.
// - Loop keeps each bit; turning it off clears the stage.
// - Left shift is the second adder adding the value to itself.
// - Multiply adds multiplicand per one bit, shifts right, covers all bits.
// - Multiply takes two multiplier bits a step, shifting right by two.
// - Shift path feeds self-add and the multiplicand into the second adder.
// - Operand word is 22 bits: 20 data, sign and parity.
// - Five clock phases 00..08, each one fifth period after the previous.
`timescale 1ns/100ps
`default_nettype none

module psacc_top
    import psacc_pkg::*;
#(
    parameter int BITS = PSACC_BITS
)(
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire logic              start,
    input  wire psacc_op_t         op,
    input  wire logic [BITS+1:0]   md_word,
    input  wire logic [BITS:0]     aux_word,
    output logic [BITS-1:0]        acc,
    output logic [PSACC_XW-1:0]    acc_ext,
    output logic                   sign,
    output logic                   ovf,
    output logic                   par_err,
    output logic                   busy,
    output logic                   done,
    output logic [PSACC_PH-1:0]    phase,
    output logic [BITS-1:0]        prod_lo
);

    localparam int PW    = $clog2(BITS);
    localparam int STEPS = BITS / 2;
    localparam int SW    = $clog2(STEPS + 1);
    localparam int SGN   = BITS;       // Sign position in both words
    localparam int PAR   = BITS + 1;   // Parity position in operand word

    if (BITS < 4 || BITS % 2 != 0) begin : g_bits_chk
        $error("psacc_top: BITS must be even and at least 4");
    end

    // ==========================================================
    // Sequencer state
    typedef enum logic [2:0] {S_IDLE, S_WAIT, S_WAVE, S_FIN, S_SHR} psacc_st_t;

    typedef struct packed {
        logic [PSACC_PH-1:0] ph;
        psacc_st_t           st;
        logic [PW-1:0]       pos;
        psacc_op_t           op;
        logic                cmp_run;
        logic [SW-1:0]       step;
        logic [BITS-1:0]     mlt;
        logic                sgn;
        logic                ovf;
        logic [PSACC_XW-1:0] ext;
        logic                busy;
        logic                done;
        logic                perr;
    } psacc_state_t;

    psacc_state_t q_r;
    psacc_state_t q_nxt;
    psacc_ctl_t   ctl;
    logic         cin0;
    logic         is_sub;
    logic [BITS-1:0] acc_w;

    psacc_stage_if sif [BITS] ();

    // ==========================================================
    // Stages, one phase apart
    genvar gi;
    generate
        for (gi = 0; gi < BITS; gi++) begin : g_stage
            assign sif[gi].go    = q_r.st == S_WAVE && q_r.pos == PW'(gi);
            assign sif[gi].load  = q_r.st == S_SHR;
            assign sif[gi].ctl   = ctl;
            assign sif[gi].md_b  = md_word[gi];
            assign sif[gi].aux_b = aux_word[gi];
            if (gi == 0) begin : g_lsb
                assign sif[gi].cin1  = cin0;
                assign sif[gi].cin2  = 1'b0;
                assign sif[gi].md_lo = 1'b0;
            end else begin : g_up
                assign sif[gi].cin1  = sif[gi-1].c1_q;
                assign sif[gi].cin2  = sif[gi-1].c2_q;
                assign sif[gi].md_lo = md_word[gi-1];
            end
            if (gi + 2 < BITS) begin : g_shr
                assign sif[gi].load_bit = sif[gi+2].bit_q;
            end else begin : g_shx
                assign sif[gi].load_bit = q_r.ext[gi+2-BITS];
            end
            assign acc_w[gi] = sif[gi].bit_q;
            psacc_stage u_stage (
                .clock   (clock),
                .sys_rst (sys_rst),
                .sif     (sif[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Control line decode
    always_comb begin
        ctl    = '0;
        is_sub = q_r.op == PSACC_SUB_MD || q_r.op == PSACC_SUB_AUX;
        if (q_r.cmp_run) begin
            ctl.recirc  = 1'b1;
            ctl.inv_acc = 1'b1;
        end else begin
            unique case (q_r.op)
                PSACC_ADD_MD:  begin ctl.recirc = 1'b1; ctl.use_md = 1'b1; end
                PSACC_SUB_MD:  begin
                    ctl.recirc = 1'b1; ctl.use_md = 1'b1; ctl.inv_opnd = 1'b1;
                end
                PSACC_ADD_AUX: begin ctl.recirc = 1'b1; ctl.use_aux = 1'b1; end
                PSACC_SUB_AUX: begin
                    ctl.recirc = 1'b1; ctl.use_aux = 1'b1; ctl.inv_opnd = 1'b1;
                end
                PSACC_SHL:     begin ctl.recirc = 1'b1; ctl.self_add = 1'b1; end
                PSACC_CLR:     ctl = '0;
                PSACC_CMP:     begin ctl.recirc = 1'b1; ctl.inv_acc = 1'b1; end
                PSACC_MUL:     begin
                    ctl.recirc = 1'b1;
                    ctl.use_md = q_r.mlt[0];
                    ctl.mul_hi = q_r.mlt[1];
                end
            endcase
        end
        cin0 = ctl.inv_opnd | ctl.inv_acc;
    end

    // ==========================================================
    // Sequencer
    always_comb begin
        q_nxt      = q_r;
        q_nxt.done = 1'b0;
        q_nxt.ph   = {q_r.ph[PSACC_PH-2:0], q_r.ph[PSACC_PH-1]};
        unique case (q_r.st)
            S_IDLE: if (start) begin
                q_nxt.op      = op;
                q_nxt.st      = S_WAIT;
                q_nxt.busy    = 1'b1;
                q_nxt.step    = '0;
                q_nxt.cmp_run = 1'b0;
                q_nxt.ovf     = 1'b0;
                q_nxt.ext     = '0;
                q_nxt.perr    = (op == PSACC_ADD_MD || op == PSACC_SUB_MD
                    || op == PSACC_MUL) && (^md_word != PSACC_PAR_ODD);
                if (op == PSACC_MUL) begin
                    q_nxt.mlt = aux_word[BITS-1:0];
                    q_nxt.sgn = md_word[SGN] ^ aux_word[SGN];
                end else if (op == PSACC_CMP) begin
                    q_nxt.sgn = ~q_r.sgn;
                end
            end
            // Every wave opens on phase 00 so stage n always owns one phase
            S_WAIT: if (q_r.ph[PSACC_PH-1]) begin
                q_nxt.st  = S_WAVE;
                q_nxt.pos = '0;
            end
            S_WAVE: begin
                q_nxt.pos = PW'(q_r.pos + 1'b1);
                if (q_r.pos == PW'(BITS - 1)) begin
                    q_nxt.st = S_FIN;
                end
            end
            S_FIN: begin
                if (q_r.op == PSACC_MUL && !q_r.cmp_run) begin
                    q_nxt.ext = PSACC_XW'(sif[BITS-1].c1_q)
                              + PSACC_XW'(sif[BITS-1].c2_q)
                              + PSACC_XW'(q_r.mlt[1] & md_word[BITS-1]);
                    q_nxt.st  = S_SHR;
                end else if (is_sub && !q_r.cmp_run && !sif[BITS-1].c1_q) begin
                    q_nxt.cmp_run = 1'b1;
                    q_nxt.sgn     = ~q_r.sgn;
                    q_nxt.st      = S_WAIT;
                end else begin
                    if (!q_r.cmp_run && (q_r.op == PSACC_ADD_MD
                        || q_r.op == PSACC_ADD_AUX)) begin
                        q_nxt.ovf = sif[BITS-1].c1_q;
                    end else if (q_r.op == PSACC_SHL) begin
                        q_nxt.ovf = sif[BITS-1].c2_q;
                    end
                    q_nxt.ext  = {1'b0, q_nxt.ovf};
                    q_nxt.st   = S_IDLE;
                    q_nxt.busy = 1'b0;
                    q_nxt.done = 1'b1;
                end
            end
            S_SHR: begin
                q_nxt.mlt  = {acc_w[1:0], q_r.mlt[BITS-1:2]};
                q_nxt.ext  = '0;
                q_nxt.step = SW'(q_r.step + 1'b1);
                if (q_r.step == SW'(STEPS - 1)) begin
                    q_nxt.st   = S_IDLE;
                    q_nxt.busy = 1'b0;
                    q_nxt.done = 1'b1;
                end else begin
                    q_nxt.st = S_WAIT;
                end
            end
            default: q_nxt.st = S_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q_r    <= '0;
            q_r.ph <= PSACC_PH'(1);
            q_r.st <= S_IDLE;
            q_r.op <= PSACC_CLR;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign acc     = acc_w;
    assign acc_ext = q_r.ext;
    assign sign    = q_r.sgn;
    assign ovf     = q_r.ovf;
    assign par_err = q_r.perr;
    assign busy    = q_r.busy;
    assign done    = q_r.done;
    assign phase   = q_r.ph;
    assign prod_lo = q_r.mlt;

    // ==========================================================
    // Checks
    localparam int LAG_MAX = 5;
    logic [BITS-1:0]   acc0_r;
    logic [BITS+1:0]   md0_r;
    logic [BITS:0]     aux0_r;
    logic [BITS:0]     dif_w;
    always_ff @(posedge clock) begin
        if (q_r.st == S_IDLE && start) begin
            acc0_r <= acc_w;
            md0_r  <= md_word;
            aux0_r <= aux_word;
        end
    end
    assign dif_w = {1'b0, acc0_r} - {1'b0, md0_r[BITS-1:0]};
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    ring_hot_a: assert property ($onehot(phase)
        and (phase[PSACC_PH-1] |=> phase[0]))
        else $error("phase ring not one-hot or not rotating");
    wave_phase_a: assert property (q_r.st == S_WAIT && phase[PSACC_PH-1]
        |=> q_r.st == S_WAVE && phase[0] && q_r.pos == '0)
        else $error("wave did not open on phase 00");
    wave_step_a: assert property (q_r.st == S_WAVE && q_r.pos != PW'(BITS-1)
        |=> q_r.st == S_WAVE && q_r.pos == $past(q_r.pos) + 1'b1)
        else $error("wave skipped a stage");
    add_sum_a: assert property (done && q_r.op == PSACC_ADD_MD
        |-> {ovf, acc} == {1'b0, acc0_r} + {1'b0, md0_r[BITS-1:0]})
        else $error("add result wrong");
    sub_diff_a: assert property (done && q_r.op == PSACC_SUB_MD
        |-> acc == (dif_w[BITS] ? BITS'(-dif_w) : dif_w[BITS-1:0]))
        else $error("subtract magnitude wrong");
    sub_cmp_a: assert property (q_r.st == S_FIN && q_r.op == PSACC_SUB_MD
        && !q_r.cmp_run && !sif[BITS-1].c1_q |=> q_r.cmp_run
        && sign != $past(sign) ##[1:LAG_MAX] q_r.st == S_WAVE)
        else $error("borrow not followed by complement");
    clr_zero_a: assert property (done && q_r.op == PSACC_CLR |-> acc == '0)
        else $error("clear left bits set");
    shl_double_a: assert property (done && q_r.op == PSACC_SHL
        |-> acc == {acc0_r[BITS-2:0], 1'b0} && ovf == acc0_r[BITS-1])
        else $error("left shift wrong");
    mul_prod_a: assert property (done && q_r.op == PSACC_MUL
        |-> {acc, prod_lo} == (2*BITS)'(md0_r[BITS-1:0]) * aux0_r[BITS-1:0]
            + (2*BITS)'(acc0_r))
        else $error("product wrong");
    mul_steps_a: assert property (q_r.st == S_SHR && q_r.step == SW'(STEPS-1)
        |=> done && !busy)
        else $error("multiply step count wrong");
    par_chk_a: assert property (q_r.st == S_IDLE && start && op == PSACC_ADD_MD
        |=> par_err == (^$past(md_word) != PSACC_PAR_ODD))
        else $error("parity flag wrong");
    add_ovf_c: cover property (done && q_r.op == PSACC_ADD_MD && ovf);
    sub_neg_c: cover property (done && q_r.op == PSACC_SUB_MD && q_r.cmp_run);
    mul_done_c: cover property (done && q_r.op == PSACC_MUL);
    shl_out_c: cover property (done && q_r.op == PSACC_SHL && ovf);
endmodule : psacc_top

`default_nettype wire

// >>> dv/phase_skewed_accumulator_tb.sv
// Self-checking bench of the phase skewed accumulator
`timescale 1ns/100ps
`default_nettype none

module phase_skewed_accumulator_tb
    import psacc_pkg::*;
;
    typedef struct packed {
        logic [PSACC_BITS-1:0] acc;
        logic [PSACC_BITS-1:0] prod;
        logic                  sgn;
        logic                  ovf;
    } psacc_exp_t;

    logic                  clock;
    logic                  sys_rst;
    logic                  start;
    psacc_op_t             op;
    logic [PSACC_BITS+1:0] md_word;
    logic [PSACC_BITS:0]   aux_word;
    logic [PSACC_BITS-1:0] acc;
    logic [PSACC_XW-1:0]   acc_ext;
    logic                  sign;
    logic                  ovf;
    logic                  par_err;
    logic                  busy;
    logic                  done;
    logic [PSACC_PH-1:0]   phase;
    logic [PSACC_BITS-1:0] prod_lo;
    int                    fail_count = 0;
    int                    check_count = 0;
    int                    cyc = 0;
    logic [31:0]           rnd;
    psacc_exp_t            st;

    psacc_top #(.BITS(PSACC_BITS)) u_dut (
        .clock(clock), .sys_rst(sys_rst), .start(start), .op(op),
        .md_word(md_word), .aux_word(aux_word), .acc(acc),
        .acc_ext(acc_ext), .sign(sign), .ovf(ovf), .par_err(par_err),
        .busy(busy), .done(done), .phase(phase), .prod_lo(prod_lo)
    );

    psacc_ctl_model u_ctl (
        .clock(clock), .busy(busy), .done(done), .start(start),
        .op(op), .md_word(md_word), .aux_word(aux_word)
    );

    always #20 clock = ~clock;

    // ==========================================================
    // Hang guard: the whole run needs well under ten thousand cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            $display("CHECK FAILED at %0t: run did not finish", $time);
            close_out();
        end
    end

    // ==========================================================
    // Expectations
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic psacc_exp_t expect_op(input psacc_exp_t s,
            input psacc_op_t o, input logic [21:0] m, input logic [20:0] a);
        psacc_exp_t  r;
        logic [20:0] sum;
        logic [19:0] v;
        r     = s;
        r.ovf = 1'b0;
        v     = (o == PSACC_ADD_AUX || o == PSACC_SUB_AUX) ? a[19:0] : m[19:0];
        sum   = {1'b0, s.acc} + {1'b0, v};
        case (o)
            PSACC_ADD_MD, PSACC_ADD_AUX: {r.ovf, r.acc} = sum;
            PSACC_SUB_MD, PSACC_SUB_AUX: begin
                r.acc = (s.acc < v) ? v - s.acc : s.acc - v;
                r.sgn = s.sgn ^ (s.acc < v);
            end
            PSACC_SHL: {r.ovf, r.acc} = {s.acc, 1'b0};
            PSACC_CLR: r.acc = '0;
            PSACC_CMP: begin
                r.acc = -s.acc;
                r.sgn = ~s.sgn;
            end
            default: begin
                {r.acc, r.prod} = m[19:0] * a[19:0] + s.acc;
                r.sgn = m[20] ^ a[20];
            end
        endcase
        return r;
    endfunction : expect_op

    // ==========================================================
    // Comparisons and report
    task automatic chk_word(input logic [39:0] got, input logic [39:0] exp,
                            input string what);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h want %h",
                     $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic got, input logic exp,
                            input string what);
        chk_word(40'(got), 40'(exp), what);
    endtask : chk_flag

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // ==========================================================
    // Operations
    task automatic do_op(input psacc_op_t o, input logic [20:0] d,
                         input logic [20:0] x, input int gap,
                         input bit spur, input bit bad);
        logic [21:0] m;
        psacc_exp_t  nx;
        int          lo;
        int          hi;
        m  = {~(^d) ^ bad, d};
        nx = expect_op(st, o, m, x);
        lo = (o == PSACC_MUL) ? 215 : 22;
        hi = (o == PSACC_MUL) ? 270 : 28;
        if ((o == PSACC_SUB_MD || o == PSACC_SUB_AUX) && nx.sgn != st.sgn) begin
            lo = 44;
            hi = 56;
        end
        u_ctl.run(o, m, x, gap, spur);
        chk_flag(par_err, bad, "parity flag");
        if (!bad) begin
            chk_flag(u_ctl.busy_seen, 1'b1, "busy");
            chk_flag(u_ctl.done_long, 1'b0, "done width");
            chk_flag(u_ctl.cycles >= lo && u_ctl.cycles <= hi, 1'b1,
                     "op length");
            chk_word({acc, prod_lo}, {nx.acc, nx.prod},
                     "acc and product");
            chk_flag(sign, nx.sgn, "sign");
            chk_flag(ovf, nx.ovf, "carry out");
            if (o inside {PSACC_ADD_MD, PSACC_ADD_AUX, PSACC_SHL, PSACC_MUL})
            begin
                chk_word(40'(acc_ext), 40'({1'b0, nx.ovf}),
                         "top stage");
            end
            st = nx;
        end
    endtask : do_op

    // Adding all ones to zero must set one more low bit each cycle
    task automatic ripple;
        int          chg;
        logic [19:0] prev;
        logic        ok;
        chg  = 0;
        ok   = 1'b1;
        prev = acc;
        fork
            do_op(PSACC_ADD_MD, 21'h0FFFFF, 21'h000000, 0, 0, 0);
            repeat (40) begin
                @(negedge clock);
                chg += int'(acc !== prev);
                ok &= ((acc & (acc + 20'h00001)) == 20'h00000);
                prev = acc;
            end
        join
        chk_word(40'(chg), 40'(PSACC_BITS), "stage steps");
        chk_flag(ok, 1'b1, "low to high order");
    endtask : ripple

    // ==========================================================
    // Main sequence
    initial begin
        logic [PSACC_PH-1:0] prev;
        logic [20:0]         d;
        int                  k;
        clock   = 1'b0;
        sys_rst = 1'b1;
        rnd     = 32'h00016A1C;
        st      = '0;
        @(posedge clock);
        @(negedge clock);
        chk_word({acc, prod_lo}, 40'h0000000000, "reset data");
        chk_word(40'({acc_ext, sign, ovf, par_err, busy, done}),
                 40'h0000000000, "reset flags");
        chk_word(40'(phase), 40'h0000000001, "reset phase");
        @(posedge clock);
        sys_rst <= 1'b0;
        @(negedge clock);
        prev = phase;
        for (k = 0; k < 8; k++) begin
            @(negedge clock);
            chk_word(40'(phase), 40'({prev[3:0], prev[4]}),
                     "phase ring");
            prev = phase;
        end
        do_op(PSACC_CLR, 21'h000000, 21'h000000, 0, 0, 0);
        ripple();
        do_op(PSACC_ADD_AUX, 21'h000000, 21'h000001, 0, 0, 0);
        do_op(PSACC_SUB_MD, 21'h000005, 21'h000000, 1, 0, 0);
        do_op(PSACC_ADD_MD, 21'h080000, 21'h000000, 0, 0, 0);
        do_op(PSACC_SHL, 21'h000000, 21'h000000, 0, 0, 0);
        do_op(PSACC_CMP, 21'h000000, 21'h000000, 0, 0, 0);
        do_op(PSACC_SUB_AUX, 21'h000000, 21'h07FFF5, 0, 0, 0);
        do_op(PSACC_MUL, 21'h1FFFFF, 21'h0FFFFF, 0, 1, 0);
        do_op(PSACC_CLR, 21'h000000, 21'h000000, 0, 1, 0);
        do_op(PSACC_MUL, 21'h000003, 21'h1AAAAA, 0, 0, 0);
        for (k = 0; k < 60; k++) begin
            rnd = lfsr_next(rnd);
            d   = rnd[20:0];
            rnd = lfsr_next(lfsr_next(rnd));
            do_op(psacc_op_t'(rnd[31:29]), d, rnd[20:0], int'(rnd[22]),
                  rnd[23] & rnd[24], 1'b0);
        end
        do_op(PSACC_ADD_MD, 21'h000003, 21'h000000, 0, 0, 1);
        close_out();
    end
endmodule : phase_skewed_accumulator_tb

`default_nettype wire

// >>> dv/psacc_ctl_model.sv
// Control unit pulse lines and operand registers facing the accumulator
`timescale 1ns/100ps
`default_nettype none

module psacc_ctl_model
    import psacc_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 busy,
    input  wire logic                 done,
    output var  logic                 start,
    output var  psacc_op_t            op,
    output var  logic [PSACC_BITS+1:0] md_word,
    output var  logic [PSACC_BITS:0]  aux_word
);
    int   cycles;
    logic busy_seen;
    logic done_long;

    initial begin
        start    = 1'b0;
        op       = PSACC_CLR;
        md_word  = '0;
        aux_word = '0;
    end

    // ==========================================================
    // One instruction
    // Stages read operands live, so they stand until done
    task automatic run(input psacc_op_t o,
                       input logic [PSACC_BITS+1:0] m,
                       input logic [PSACC_BITS:0] a,
                       input int gap,
                       input bit spur);
        int n;
        n = 1;
        repeat (gap) @(posedge clock);
        @(posedge clock);
        start    <= 1'b1;
        op       <= o;
        md_word  <= m;
        aux_word <= a;
        @(posedge clock);
        start <= 1'b0;
        @(negedge clock);
        busy_seen = busy;
        while (done !== 1'b1 && n < 400) begin
            @(posedge clock);
            n++;
            // A stray start while busy, which must be ignored
            start <= spur && (n == 5);
            @(negedge clock);
        end
        cycles = n;
        @(posedge clock);
        // Released lines show the inverse rather than a stale copy
        md_word  <= ~m;
        aux_word <= ~a;
        @(negedge clock);
        done_long = done;
    endtask : run
endmodule : psacc_ctl_model

`default_nettype wire
